// >>> src/tmr_ctrl.sv
// Behaviour
// - force strobe acts only outside pwm modes
// - force b applies compare action immediately
// - force b sets no flag, no clear
// - force b bit always reads zero
// - control b bits 5:4 read zero
// - clock select: stop, div 1/8/64/256/1024
// - codes 110/111: external pin fall/rise
// - pin edges count even as output
// - counter rw; write blocks next match
// - compare a checked every timer clock
// - compare b checked every timer clock
// - irq a: mask bit 4, global, flag
// - irq b: mask bit 3, global, flag
// - irq ovf: mask bit 1, global, flag
// - flag 4 set on match a, cleared
// - flag 3 set on match b, cleared
// - flag 1 set on mode overflow point
// - mode bits choose waveform and top
// - non-pwm compare output field actions
`include "tmr_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tmr_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side
  input wire logic cpu_irq_enable,
  input wire tmr_pkg::tmr_evt_t vector_ack,
  output tmr_pkg::tmr_evt_t irq_req,
  // pins
  input wire logic external_count_input,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_oe_a,
  output logic wave_oe_b
);
  import tmr_pkg::*;

  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [7:0] counter_value;
  logic [1:0] compare_output_mode_a;
  logic [1:0] compare_output_mode_b;
  logic [1:0] waveform_mode_field;
  logic waveform_mode_bit2;
  logic [2:0] clock_select_field;
  tmr_evt_t flags;
  tmr_evt_t irq_en;
  tmr_mode_t mode;
  logic [9:0] presc;
  logic ext_q;
  logic tick;
  logic blk;
  logic count_up;
  logic [7:0] top;
  logic non_pwm;
  logic fast;
  logic wrap;
  logic ovf_evt;
  logic [1:0] match;
  logic [1:0] force_cmp;
  logic [1:0] com [2];
  logic [7:0] ocr [2];
  logic wave [2];
  logic setup;
  logic wr;
  logic hit;
  logic [7:0] idx;
  logic [7:0] next_rd;

  // bus decode; zero wait states
  assign pready = 1'b1;
  assign idx = {2'h0, paddr[7:2]};
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;

  // address decode and read mux
  always_comb begin
    hit = 1'b1;
    next_rd = `TMR_RST_VAL;
    case (idx)
      `TMR_IDX_CMP_B: next_rd = compare_value_b;
      `TMR_IDX_CMP_A: next_rd = compare_value_a;
      `TMR_IDX_CTRL_A: next_rd = {compare_output_mode_a,
        compare_output_mode_b, 2'h0, waveform_mode_field};
      `TMR_IDX_CNT: next_rd = counter_value;
      // strobes and reserved bits read zero
      `TMR_IDX_CTRL_B: next_rd = {4'h0, waveform_mode_bit2,
        clock_select_field};
      `TMR_IDX_FLAGS: next_rd = {3'h0, flags.a, flags.b, 1'b0,
        flags.ovf, 1'b0};
      `TMR_IDX_MASK: next_rd = {3'h0, irq_en.a, irq_en.b, 1'b0,
        irq_en.ovf, 1'b0};
      default: hit = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= {24'h0, next_rd};
    end
  end

  // error flag for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !hit;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_a <= `TMR_RST_VAL;
      compare_value_b <= `TMR_RST_VAL;
      compare_output_mode_a <= 2'h0;
      compare_output_mode_b <= 2'h0;
      waveform_mode_field <= 2'h0;
      waveform_mode_bit2 <= 1'b0;
      clock_select_field <= `TMR_CS_STOP;
      irq_en <= '0;
    end else if (wr) begin
      case (idx)
        `TMR_IDX_CMP_A: compare_value_a <= pwdata[7:0];
        `TMR_IDX_CMP_B: compare_value_b <= pwdata[7:0];
        `TMR_IDX_CTRL_A: begin
          compare_output_mode_a <= pwdata[`TMR_COM_A_HI -: 2];
          compare_output_mode_b <= pwdata[`TMR_COM_B_HI -: 2];
          waveform_mode_field <= pwdata[1:0];
        end
        `TMR_IDX_CTRL_B: begin
          waveform_mode_bit2 <= pwdata[`TMR_WGM2_BIT];
          clock_select_field <= pwdata[2:0];
        end
        `TMR_IDX_MASK: irq_en <= {pwdata[`TMR_A_BIT],
          pwdata[`TMR_B_BIT], pwdata[`TMR_OVF_BIT]};
        default: ;
      endcase
    end
  end

  // mode decode and top value
  assign mode = tmr_mode_t'({waveform_mode_bit2, waveform_mode_field});
  assign non_pwm = !waveform_mode_field[0];
  assign fast = (waveform_mode_field == 2'h3);
  always_comb begin
    case (mode)
      TMR_CTC, TMR_PC_CMPA, TMR_FAST_CMPA: top = compare_value_a;
      default: top = `TMR_MAX;
    endcase
  end

  // free running prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 10'h0;
    end else begin
      presc <= presc + 10'h1;
    end
  end

  // pin history for edge detection, also when pin is an output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= external_count_input;
    end
  end

  // timer clock enable from the selected source
  always_comb begin
    case (clock_select_field)
      `TMR_CS_DIV1: tick = 1'b1;
      `TMR_CS_DIV8: tick = &presc[2:0];
      `TMR_CS_DIV64: tick = &presc[5:0];
      `TMR_CS_DIV256: tick = &presc[7:0];
      `TMR_CS_DIV1024: tick = &presc;
      `TMR_CS_EXT_FALL: tick = ext_q && !external_count_input;
      `TMR_CS_EXT_RISE: tick = !ext_q && external_count_input;
      default: tick = 1'b0;
    endcase
  end

  // end of a period and overflow point per mode
  assign wrap = tick && !mode[0] ? counter_value == top :
    tick && counter_value == top;
  always_comb begin
    case (mode)
      TMR_PC_FF, TMR_PC_CMPA:
        ovf_evt = tick && !count_up && counter_value == `TMR_BOTTOM;
      TMR_FAST_CMPA: ovf_evt = tick && counter_value == top;
      default: ovf_evt = tick && counter_value == `TMR_MAX;
    endcase
  end

  // counter, direct write wins over counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= `TMR_RST_VAL;
      count_up <= 1'b1;
    end else if (wr && idx == `TMR_IDX_CNT) begin
      counter_value <= pwdata[7:0];
    end else if (tick && (mode == TMR_PC_FF || mode == TMR_PC_CMPA)) begin
      if (count_up && counter_value == top) begin
        count_up <= 1'b0;
        counter_value <= counter_value - 8'h1;
      end else if (!count_up && counter_value == `TMR_BOTTOM) begin
        count_up <= 1'b1;
        counter_value <= counter_value + 8'h1;
      end else begin
        counter_value <= count_up ? counter_value + 8'h1 :
          counter_value - 8'h1;
      end
    end else if (tick) begin
      count_up <= 1'b1;
      counter_value <= wrap ? `TMR_BOTTOM : counter_value + 8'h1;
    end
  end

  // compare blocking until the next timer clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk <= 1'b0;
    end else if (wr && idx == `TMR_IDX_CNT) begin
      blk <= 1'b1;
    end else if (tick) begin
      blk <= 1'b0;
    end
  end

  // per channel compare and waveform
  assign ocr[0] = compare_value_a;
  assign ocr[1] = compare_value_b;
  assign com[0] = compare_output_mode_a;
  assign com[1] = compare_output_mode_b;
  assign force_cmp[0] = wr && idx == `TMR_IDX_CTRL_B &&
    pwdata[`TMR_FORCE_A_BIT];
  assign force_cmp[1] = wr && idx == `TMR_IDX_CTRL_B &&
    pwdata[`TMR_FORCE_B_BIT];
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      assign match[i] = tick && !blk && counter_value == ocr[i];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wave[i] <= 1'b0;
        end else if (non_pwm && (force_cmp[i] || match[i])) begin
          // forced compare only in non-pwm modes
          case (com[i])
            2'h1: wave[i] <= !wave[i];
            2'h2: wave[i] <= 1'b0;
            2'h3: wave[i] <= 1'b1;
            default: ;
          endcase
        end else if (fast && com[i][1]) begin
          if (match[i] && ocr[i] != top) begin
            wave[i] <= com[i][0];
          end else if (wrap) begin
            wave[i] <= !com[i][0];
          end
        end else if (!non_pwm && com[i][1] && match[i]) begin
          wave[i] <= count_up ? com[i][0] : !com[i][0];
        end
      end
    end
  endgenerate

  // waveform pins
  assign wave_out_a = wave[0] && compare_output_mode_a != 2'h0;
  assign wave_out_b = wave[1] && compare_output_mode_b != 2'h0;
  assign wave_oe_a = compare_output_mode_a != 2'h0;
  assign wave_oe_b = compare_output_mode_b != 2'h0;

  // sticky flags; hardware set beats write-one or vector clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags.a <= match[0] || (flags.a && !vector_ack.a &&
        !(wr && idx == `TMR_IDX_FLAGS && pwdata[`TMR_A_BIT]));
      flags.b <= match[1] || (flags.b && !vector_ack.b &&
        !(wr && idx == `TMR_IDX_FLAGS && pwdata[`TMR_B_BIT]));
      flags.ovf <= ovf_evt || (flags.ovf && !vector_ack.ovf &&
        !(wr && idx == `TMR_IDX_FLAGS && pwdata[`TMR_OVF_BIT]));
    end
  end

  // interrupt requests
  assign irq_req.a = cpu_irq_enable && irq_en.a && flags.a;
  assign irq_req.b = cpu_irq_enable && irq_en.b && flags.b;
  assign irq_req.ovf = cpu_irq_enable && irq_en.ovf && flags.ovf;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_force_no_flag: assert property (
    force_cmp[1] && !match[1] && !flags.b |=> !flags.b)
    else $error("forced compare set a flag");
  a_force_no_clear: assert property (
    force_cmp[1] && !tick |=> $stable(counter_value))
    else $error("forced compare moved the counter");
  a_force_wave: assert property (
    force_cmp[1] && non_pwm && compare_output_mode_b == 2'h3
    |=> wave_out_b)
    else $error("forced set did not drive output b");
  a_ctrlb_read: assert property (
    setup && !pwrite && idx == `TMR_IDX_CTRL_B |=> prdata[7:4] == 4'h0)
    else $error("control b strobe or reserved bits read nonzero");
  a_stop_hold: assert property (
    clock_select_field == `TMR_CS_STOP && !wr |=> $stable(counter_value))
    else $error("stopped counter moved");
  a_div8_tap: assert property (
    clock_select_field == `TMR_CS_DIV8 && tick |-> presc[2:0] == 3'h7)
    else $error("divide by 8 tick misplaced");
  a_ext_fall: assert property (
    clock_select_field == `TMR_CS_EXT_FALL && $fell(external_count_input)
    |-> tick)
    else $error("falling pin edge not counted");

  // helper: counter write still waiting for its first timer clock
  logic cnt_wr_pend;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_wr_pend <= 1'b0;
    end else if (wr && idx == `TMR_IDX_CNT) begin
      cnt_wr_pend <= 1'b1;
    end else if (tick) begin
      cnt_wr_pend <= 1'b0;
    end
  end
  a_write_block: assert property (
    cnt_wr_pend && tick && flags == '0 |=> !flags.a && !flags.b)
    else $error("compare not blocked after counter write");
  a_ctc_clear: assert property (
    mode == TMR_CTC && tick && counter_value == compare_value_a && !wr
    |=> counter_value == `TMR_BOTTOM)
    else $error("clear on compare a did not restart the counter");
  a_match_flag_a: assert property (match[0] |=> flags.a)
    else $error("compare a match lost");
  a_match_flag_b: assert property (match[1] |=> flags.b)
    else $error("compare b match lost");
  a_ovf_flag: assert property (ovf_evt |=> flags.ovf)
    else $error("overflow not flagged");
  a_clear_one: assert property (
    flags.a && wr && idx == `TMR_IDX_FLAGS && pwdata[`TMR_A_BIT] &&
    !match[0] |=> !flags.a)
    else $error("write one did not clear flag a");
  a_irq_gate: assert property (
    !cpu_irq_enable |-> irq_req == '0)
    else $error("interrupt requested with global enable off");

  c_match_a: cover property (match[0] && flags.a == 1'b0);
  c_overflow: cover property (ovf_evt);
  c_force_b: cover property (force_cmp[1] && non_pwm);
  c_set_vs_clear: cover property (match[1] && vector_ack.b);
  c_ctc_wrap: cover property (mode == TMR_CTC && wrap);
endmodule : tmr_ctrl
`default_nettype wire

// >>> pkg/tmr_defines.svh
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
// register indices; byte address is four times the index
`define TMR_IDX_CMP_B 8'h28
`define TMR_IDX_CMP_A 8'h29
`define TMR_IDX_CTRL_A 8'h2A
`define TMR_IDX_CNT 8'h32
`define TMR_IDX_CTRL_B 8'h33
`define TMR_IDX_FLAGS 8'h38
`define TMR_IDX_MASK 8'h39
// field positions
`define TMR_COM_A_HI 7
`define TMR_COM_B_HI 5
`define TMR_FORCE_A_BIT 7
`define TMR_FORCE_B_BIT 6
`define TMR_WGM2_BIT 3
`define TMR_A_BIT 4
`define TMR_B_BIT 3
`define TMR_OVF_BIT 1
// reset value of every register
`define TMR_RST_VAL 8'h00
// clock select codes
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7
// counter limits
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00
`endif

// >>> pkg/tmr_pkg.sv
package tmr_pkg;
  // one bit per timer event: compare a, compare b, overflow
  typedef struct packed {
    logic a;
    logic b;
    logic ovf;
  } tmr_evt_t;
  // waveform mode, bit 2 from control b, bits 1:0 from control a
  typedef enum logic [2:0] {
    TMR_NORMAL, TMR_PC_FF, TMR_CTC, TMR_FAST_FF,
    TMR_RSV4, TMR_PC_CMPA, TMR_RSV6, TMR_FAST_CMPA
  } tmr_mode_t;
endpackage : tmr_pkg

// >>> tb/tb_tmr_ctrl.sv
`include "tmr_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_tmr_ctrl;
  import tmr_pkg::*;
  // bench signals
  logic pclk, presetn, psel, penable, pwrite, cpu_irq_enable;
  logic external_count_input, pready, pslverr, er_v;
  logic wave_out_a, wave_out_b, wave_oe_a, wave_oe_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  tmr_evt_t vector_ack, irq_req;
  int err_count, cmp_count, i, d;
  logic [1:0] com_tab [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic exp_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] idx_tab [7] = '{`TMR_IDX_CMP_B, `TMR_IDX_CMP_A, `TMR_IDX_CTRL_A,
    `TMR_IDX_CNT, `TMR_IDX_CTRL_B, `TMR_IDX_FLAGS, `TMR_IDX_MASK};

  // device under test
  tmr_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_irq_enable(cpu_irq_enable),
    .vector_ack(vector_ack), .irq_req(irq_req),
    .external_count_input(external_count_input), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .wave_oe_a(wave_oe_a), .wave_oe_b(wave_oe_b)
  );

  // 125 mhz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // exact value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // count within a window, phase of the prescaler is free
  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo,
                         input logic [7:0] hi, input string what);
    cmp_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_count++;
      $display("FAIL t=%0t %s got %h", $time, what, got);
    end
  endtask : chk_rng

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read a register and compare the whole word with the byte zero-extended
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp,
                       input string what);
    apb(1'b0, idx, 8'h00);
    chk(rd_v, {24'h0, exp}, what);
  endtask : rdchk

  // watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    $display("FAIL t=%0t watchdog", $time);
    tally_and_finish();
  end

  // test sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_irq_enable = 1'b0;
    vector_ack = '0;
    external_count_input = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i++) begin
      rdchk(idx_tab[i], `TMR_RST_VAL, "reset value");
    end
    apb(1'b0, 8'h30, 8'h00);
    chk({31'h0, er_v}, 32'h1, "unmapped err");
    $display("test reset done");
    apb(1'b1, `TMR_IDX_CTRL_B, 8'hF8);
    rdchk(`TMR_IDX_CTRL_B, 8'h08, "ctrl_b read");
    apb(1'b1, `TMR_IDX_CTRL_B, 8'h00);
    $display("test ctrl_b done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `TMR_IDX_CTRL_A, {com_tab[i], com_tab[i], 4'h0});
      apb(1'b1, `TMR_IDX_CTRL_B, 8'hC0);
      repeat (2) @(posedge pclk);
      chk({31'h0, wave_out_b}, {31'h0, exp_tab[i]}, "force b");
      chk({31'h0, wave_out_a}, {31'h0, exp_tab[i]}, "force a");
      chk({30'h0, wave_oe_a, wave_oe_b}, 32'h3, "wave oe");
    end
    rdchk(`TMR_IDX_FLAGS, 8'h00, "force flags");
    apb(1'b1, `TMR_IDX_CTRL_A, 8'h31);
    apb(1'b1, `TMR_IDX_CTRL_B, 8'h40);
    repeat (2) @(posedge pclk);
    chk({31'h0, wave_out_b}, 32'h0, "force in pwm");
    apb(1'b1, `TMR_IDX_CTRL_A, 8'h00);
    $display("test force done");
    apb(1'b1, `TMR_IDX_CMP_A, 8'h10);
    apb(1'b1, `TMR_IDX_CMP_B, 8'h20);
    rdchk(`TMR_IDX_CMP_B, 8'h20, "cmp_b rw");
    apb(1'b1, `TMR_IDX_CNT, 8'h00);
    apb(1'b1, `TMR_IDX_CTRL_B, {5'h0, `TMR_CS_DIV1});
    repeat (300) @(posedge pclk);
    apb(1'b1, `TMR_IDX_CTRL_B, 8'h00);
    rdchk(`TMR_IDX_FLAGS, 8'h1A, "match flags");
    $display("test match done");
    apb(1'b1, `TMR_IDX_MASK, 8'h1A);
    rdchk(`TMR_IDX_MASK, 8'h1A, "mask rw");
    cpu_irq_enable <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({29'h0, irq_req}, 32'h7, "irq all");
    cpu_irq_enable <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({29'h0, irq_req}, 32'h0, "irq global off");
    apb(1'b1, `TMR_IDX_MASK, 8'h08);
    cpu_irq_enable <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({29'h0, irq_req}, 32'h2, "irq b only");
    apb(1'b1, `TMR_IDX_FLAGS, 8'h10);
    rdchk(`TMR_IDX_FLAGS, 8'h0A, "w1c a");
    @(posedge pclk);
    vector_ack <= 3'b010;
    @(posedge pclk);
    vector_ack <= 3'b000;
    rdchk(`TMR_IDX_FLAGS, 8'h02, "vector b");
    chk({29'h0, irq_req}, 32'h0, "irq b cleared");
    apb(1'b1, `TMR_IDX_FLAGS, 8'h02);
    rdchk(`TMR_IDX_FLAGS, 8'h00, "w1c ovf");
    cpu_irq_enable <= 1'b0;
    $display("test irq done");
    apb(1'b1, `TMR_IDX_CNT, 8'h80);
    apb(1'b1, `TMR_IDX_CMP_A, 8'h05);
    apb(1'b1, `TMR_IDX_CMP_B, 8'h90);
    apb(1'b1, `TMR_IDX_CTRL_B, {5'h0, `TMR_CS_DIV1});
    apb(1'b1, `TMR_IDX_CNT, 8'h05);
    repeat (2) @(posedge pclk);
    rdchk(`TMR_IDX_FLAGS, 8'h00, "write blocks match");
    apb(1'b1, `TMR_IDX_CTRL_B, 8'h00);
    apb(1'b1, `TMR_IDX_CNT, 8'h42);
    repeat (50) @(posedge pclk);
    rdchk(`TMR_IDX_CNT, 8'h42, "stopped");
    $display("test counter done");
    for (d = 2; d <= 5; d++) begin
      apb(1'b1, `TMR_IDX_CNT, 8'h00);
      apb(1'b1, `TMR_IDX_CTRL_B, {5'h0, d[2:0]});
      repeat (8 << (d == 2 ? 3 : 2 * d)) @(posedge pclk);
      apb(1'b1, `TMR_IDX_CTRL_B, 8'h00);
      apb(1'b0, `TMR_IDX_CNT, 8'h00);
      chk_rng(rd_v[7:0], 8'h07, 8'h09, "prescaler");
    end
    $display("test prescaler done");
    for (d = 7; d >= 6; d--) begin
      apb(1'b1, `TMR_IDX_CNT, 8'h00);
      apb(1'b1, `TMR_IDX_CTRL_B, {5'h0, d[2:0]});
      repeat (3) begin
        @(posedge pclk);
        external_count_input <= 1'b1;
        repeat (4) @(posedge pclk);
        external_count_input <= 1'b0;
        repeat (4) @(posedge pclk);
      end
      rdchk(`TMR_IDX_CNT, 8'h03, "pin edges");
    end
    apb(1'b1, `TMR_IDX_CTRL_B, 8'h00);
    $display("test pin clock done");
    apb(1'b1, `TMR_IDX_CTRL_A, 8'h02);
    apb(1'b1, `TMR_IDX_CMP_A, 8'h05);
    apb(1'b1, `TMR_IDX_FLAGS, 8'h1A);
    apb(1'b1, `TMR_IDX_CNT, 8'h00);
    apb(1'b1, `TMR_IDX_CTRL_B, {5'h0, `TMR_CS_DIV1});
    repeat (300) @(posedge pclk);
    apb(1'b1, `TMR_IDX_CTRL_B, 8'h00);
    apb(1'b0, `TMR_IDX_CNT, 8'h00);
    chk_rng(rd_v[7:0], 8'h00, 8'h05, "ctc top");
    rdchk(`TMR_IDX_FLAGS, 8'h10, "ctc flags");
    apb(1'b1, `TMR_IDX_FLAGS, 8'h1A);
    apb(1'b1, `TMR_IDX_CTRL_A, 8'h00);
    $display("test ctc done");
    tally_and_finish();
  end
endmodule : tb_tmr_ctrl
`default_nettype wire
